// >>> rtl/smpc_pkg.sv
// Types shared by the stop mode power control block.
package smpc_pkg;
  typedef enum logic [3:0] {
    SMPC_RUN   = 4'h1,
    SMPC_STOP3 = 4'h2,
    SMPC_STOP2 = 4'h4,
    SMPC_STOP1 = 4'h8
  } smpc_mode_t;

  typedef struct packed {
    logic       run_clk_en;
    logic       periph_clk_en;
    logic       conv_enable;
    logic       cgen_standby;
    logic       cgen_osc_run;
    logic       cgen_off;
    logic       reg_standby;
    logic       keypad_wake_en;
    logic       pins_latched;
  } smpc_power_t;

  typedef struct packed {
    logic       wake_irq;
    logic       cpu_take_irq;
    logic       cpu_take_reset;
    logic       periph_reset;
    logic       sys_reset;
    logic       ram_lost;
  } smpc_wake_t;

  typedef struct packed {
    smpc_mode_t  mode;
    logic [7:0]  options;
    logic        opt_written;
    logic        powerdown_ctrl;
    logic        partial_powerdown_sel;
    logic        pd_written;
    logic        ppd_flag;
    logic        lv_flag;
    logic        lv_irq_en;
    logic        lv_rst_en;
    logic        lv_stop_en;
    logic        lv_det_en;
    logic [17:0] wd_count;
    logic [31:0] prdata;
    logic        pready;
    smpc_wake_t  wake;
  } smpc_state_t;
endpackage

// >>> rtl/smpc_regs.svh
// Register offsets, field positions, reset values and timing counts of the stop mode power control block.
`ifndef SMPC_REGS_SVH
`define SMPC_REGS_SVH
`define SMPC_OFS_OPTIONS     12'h000
`define SMPC_OFS_PMC1        12'h004
`define SMPC_OFS_PMC2        12'h008
`define SMPC_OFS_STOPCMD     12'h00C
`define SMPC_OFS_STATUS      12'h010
`define SMPC_OPT_WD_EN       7
`define SMPC_OPT_WD_LONG     6
`define SMPC_OPT_STOP_EN     5
`define SMPC_OPT_DBG_PIN     1
`define SMPC_OPT_RST         8'hC2
`define SMPC_OPT_MASK        8'hF3
`define SMPC_P1_FLAG         7
`define SMPC_P1_ACK          6
`define SMPC_P1_IRQ_EN       5
`define SMPC_P1_RST_EN       4
`define SMPC_P1_STOP_EN      3
`define SMPC_P1_DET_EN       2
`define SMPC_P2_PPD_FLAG     3
`define SMPC_P2_PPD_ACK      2
`define SMPC_P2_PDC          1
`define SMPC_P2_PARTIAL_POWERDOWN_SEL         0
`define SMPC_WD_LONG_BITS    18
`define SMPC_WD_SHORT_BITS   13
`endif

// >>> rtl/smpc_top.sv
// Stop mode power control: mode sequencing, write-once options and low-voltage detect control over APB.
// How it works
// R1: Stop3 holds RAM and all registers.
// R2: Stop2 wake resets registers, RAM kept, pins latched.
// R3: Stop1 wake resets registers and loses RAM.
// R4: Stop3 clock generator standby, oscillator optional.
// R5: Stop2/stop1 clock generator fully off.
// R6: Powered stop plus interrupt resumes through handler.
// R7: Unpowered stop or reset wake fetches reset vector.
// R8: Any stop halts timer, serial, converter clocks.
// R9: Stop2/stop1 wake resets the peripheral modules.
// R10: Keypad wakes stop3 only, reinitialised otherwise.
// R11: Regulator standby unless low-volt-stop or debug.
// R12: Options readable; bits 3 and 2 read zero.
// R13: Options accept only first write after reset.
// R14: Watchdog enable resets to one.
// R15: Timeout select: 2^18 or 2^13 bus cycles.
// R16: Stop while disabled forces illegal-opcode reset.
// R17: Debug pin function versus output-only port pin.
// R18: Low-voltage flag reads only while detection enabled.
// R19: Ack write one clears flag, reads zero.
// R20: Interrupt request while flag and enable set.
// R21: Reset on flag when reset and detect enabled.
// R22: Detect enable gates bits; stop bit keeps detection.
// R23: Write-once power-down and partial select bits.
// R24: Debug or low-volt-stop forces stop3 instead.
// R25: Stop2 wake sets flag; ack clears and releases pins.
//
// Design decisions made here: the APB register port and the register addresses.
`include "smpc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module smpc_top
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Core and wake events, from the same clock domain.
  input  wire logic        stop_exec,
  input  wire logic        wake_irq_event,
  input  wire logic        wake_reset_event,
  input  wire logic        wdog_service,
  input  wire logic        debug_entry_enable,
  // Analog low-voltage comparator output, asynchronous.
  input  wire logic        low_volt_raw,
  // Power and clock controls.
  output smpc_pkg::smpc_power_t power,
  output smpc_pkg::smpc_wake_t  wake,
  output logic             regs_reset,
  output logic             low_volt_irq,
  output logic             illegal_stop_reset,
  output logic             watchdog_reset,
  output logic             low_volt_reset,
  output logic             debug_pin_enable
);

  smpc_pkg::smpc_state_t st;
  smpc_pkg::smpc_state_t next_st;
  logic [1:0]            lv_sync;
  logic                  wr_acc;
  logic                  rd_acc;
  logic                  stop_allowed;
  logic                  deep_blocked;
  logic                  lv_active;
  logic [17:0]           wd_limit;

  // The comparator is asynchronous, so only the second stage is read.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      lv_sync <= 2'h0;
    else
      lv_sync <= {lv_sync[0], low_volt_raw};
  end

  always_comb
  begin
    wr_acc       = psel && penable && pwrite && st.pready;
    rd_acc       = psel && !penable && !pwrite;
    stop_allowed = st.options[`SMPC_OPT_STOP_EN];
    deep_blocked = debug_entry_enable || (st.lv_det_en && st.lv_stop_en);  // R24 R11
    lv_active    = st.lv_det_en && (st.mode == smpc_pkg::SMPC_RUN || st.lv_stop_en);  // R22
    wd_limit     = st.options[`SMPC_OPT_WD_LONG]
                 ? 18'h3FFFF : 18'h01FFF;  // R15
  end

  always_comb
  begin
    next_st      = st;
    next_st.wake = '0;
    next_st.pready = psel && !penable;

    // A detect event sets the flag even when an ack lands in the same cycle.
    if (wr_acc && paddr == `SMPC_OFS_PMC1 && pwdata[`SMPC_P1_ACK])
      next_st.lv_flag = 1'b0;  // R19
    if (lv_active && lv_sync[1])
      next_st.lv_flag = 1'b1;  // R18

    if (wr_acc)
    begin
      case (paddr)
        `SMPC_OFS_OPTIONS:
        begin
          if (!st.opt_written)
          begin
            next_st.options     = pwdata[7:0] & `SMPC_OPT_MASK;  // R13 R12
            next_st.opt_written = 1'b1;  // R13
          end
        end
        `SMPC_OFS_PMC1:
        begin
          next_st.lv_irq_en  = pwdata[`SMPC_P1_IRQ_EN];
          next_st.lv_rst_en  = pwdata[`SMPC_P1_RST_EN];
          next_st.lv_stop_en = pwdata[`SMPC_P1_STOP_EN];
          next_st.lv_det_en  = pwdata[`SMPC_P1_DET_EN];  // R22
        end
        `SMPC_OFS_PMC2:
        begin
          if (pwdata[`SMPC_P2_PPD_ACK])
            next_st.ppd_flag = 1'b0;  // R25
          if (!st.pd_written)
          begin
            next_st.powerdown_ctrl        = pwdata[`SMPC_P2_PDC];  // R23
            next_st.partial_powerdown_sel       = pwdata[`SMPC_P2_PARTIAL_POWERDOWN_SEL];  // R23
            next_st.pd_written = 1'b1;
          end
        end
        default:
        begin
        end
      endcase
    end

    // Watchdog counts in run mode only; a service write restarts it.
    if (st.mode != smpc_pkg::SMPC_RUN || wdog_service || !st.options[`SMPC_OPT_WD_EN])
      next_st.wd_count = 18'h00000;
    else if (st.wd_count != wd_limit)
      next_st.wd_count = st.wd_count + 18'h00001;

    case (st.mode)
      smpc_pkg::SMPC_RUN:
      begin
        if (stop_exec && stop_allowed)
        begin
          if (!st.powerdown_ctrl || deep_blocked)
            next_st.mode = smpc_pkg::SMPC_STOP3;  // R23 R24
          else if (st.partial_powerdown_sel)
            next_st.mode = smpc_pkg::SMPC_STOP2;  // R23
          else
            next_st.mode = smpc_pkg::SMPC_STOP1;  // R23
        end
      end
      smpc_pkg::SMPC_STOP3:
      begin
        // Register state is simply held, so nothing is touched here.
        if (wake_reset_event)
        begin
          next_st.mode                = smpc_pkg::SMPC_RUN;
          next_st.wake.cpu_take_reset = 1'b1;  // R7
          next_st.wake.sys_reset      = 1'b1;
        end
        else if (wake_irq_event)
        begin
          next_st.mode              = smpc_pkg::SMPC_RUN;  // R1
          next_st.wake.wake_irq     = 1'b1;  // R6
          next_st.wake.cpu_take_irq = 1'b1;  // R6
        end
      end
      smpc_pkg::SMPC_STOP2, smpc_pkg::SMPC_STOP1:
      begin
        if (wake_reset_event || wake_irq_event)
        begin
          next_st                     = '0;
          next_st.mode                = smpc_pkg::SMPC_RUN;
          next_st.options             = `SMPC_OPT_RST;
          next_st.ppd_flag            = (st.mode == smpc_pkg::SMPC_STOP2);  // R25 R2
          next_st.wake.cpu_take_reset = 1'b1;  // R7
          next_st.wake.periph_reset   = 1'b1;  // R9
          next_st.wake.sys_reset      = 1'b1;  // R2 R3
          next_st.wake.ram_lost       = (st.mode == smpc_pkg::SMPC_STOP1);  // R3
        end
      end
      default:
        next_st.mode = smpc_pkg::SMPC_RUN;
    endcase

    if (rd_acc)
    begin
      case (paddr)
        `SMPC_OFS_OPTIONS:
          next_st.prdata = {24'h000000, st.options & `SMPC_OPT_MASK};  // R12
        `SMPC_OFS_PMC1:
          next_st.prdata = {24'h000000, st.lv_flag && st.lv_det_en, 1'b0, st.lv_irq_en,
                            st.lv_rst_en, st.lv_stop_en, st.lv_det_en, 2'h0};  // R18 R19
        `SMPC_OFS_PMC2:
          next_st.prdata = {28'h0000000, st.ppd_flag, 1'b0, st.powerdown_ctrl, st.partial_powerdown_sel};
        `SMPC_OFS_STATUS:
          next_st.prdata = {28'h0000000, st.mode};
        default:
          next_st.prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st         <= '0;
      st.mode    <= smpc_pkg::SMPC_RUN;
      st.options <= `SMPC_OPT_RST;  // R14 R15 R16 R17
    end
    else
      st <= next_st;
  end

  always_comb
  begin
    pready  = st.pready;
    prdata  = st.prdata;
    pslverr = 1'b0;
    wake    = st.wake;
    regs_reset = st.wake.sys_reset;
    illegal_stop_reset = stop_exec && !stop_allowed && st.mode == smpc_pkg::SMPC_RUN;  // R16
    watchdog_reset = st.options[`SMPC_OPT_WD_EN] && st.wd_count == wd_limit;  // R14
    low_volt_irq   = st.lv_irq_en && st.lv_det_en && st.lv_flag;  // R20
    low_volt_reset = st.lv_rst_en && st.lv_det_en && st.lv_flag;  // R21
    debug_pin_enable = st.options[`SMPC_OPT_DBG_PIN];  // R17
    power.run_clk_en     = (st.mode == smpc_pkg::SMPC_RUN);  // R6
    power.periph_clk_en  = (st.mode == smpc_pkg::SMPC_RUN);  // R8
    power.conv_enable    = (st.mode == smpc_pkg::SMPC_RUN);  // R8
    power.cgen_standby   = (st.mode == smpc_pkg::SMPC_STOP3);  // R4
    power.cgen_osc_run   = (st.mode == smpc_pkg::SMPC_STOP3) && st.options[0];  // R4
    power.cgen_off       = (st.mode == smpc_pkg::SMPC_STOP2) || (st.mode == smpc_pkg::SMPC_STOP1);  // R5
    power.reg_standby    = (st.mode != smpc_pkg::SMPC_RUN) && !deep_blocked;  // R11
    power.keypad_wake_en = (st.mode != smpc_pkg::SMPC_STOP2) && (st.mode != smpc_pkg::SMPC_STOP1);  // R10
    power.pins_latched   = st.ppd_flag || (st.mode == smpc_pkg::SMPC_STOP2);  // R2 R25
  end

endmodule
`default_nettype wire

// >>> verif/smpc_top_sva.sv
// Port-level assertions for the stop mode power control block.
`timescale 1ns/1ps
`default_nettype none
module smpc_top_sva
(
  // Clock, reset and bus.
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pready,
  // Mode and wake.
  input wire logic                  stop_exec,
  input wire smpc_pkg::smpc_power_t power,
  input wire smpc_pkg::smpc_wake_t  wake,
  input wire logic                  regs_reset,
  input wire logic                  illegal_stop_reset,
  input wire logic                  low_volt_irq,
  input wire logic                  debug_pin_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_answer; psel && !penable |=> pready; endproperty
  property p_halt; !power.run_clk_en |-> !power.periph_clk_en && !power.conv_enable; endproperty
  property p_osc; power.cgen_osc_run |-> power.cgen_standby && !power.cgen_off; endproperty
  property p_off; power.cgen_off |-> !power.cgen_osc_run && power.reg_standby; endproperty
  property p_kbi; power.cgen_off |-> !power.keypad_wake_en; endproperty
  property p_vec; wake.cpu_take_irq |-> !wake.cpu_take_reset; endproperty
  property p_lost; wake.ram_lost |-> wake.cpu_take_reset && wake.periph_reset; endproperty
  property p_rst; regs_reset == wake.sys_reset; endproperty
  property p_ill; illegal_stop_reset |-> stop_exec && power.run_clk_en; endproperty
  property p_dbg; $fell(sys_rst) |-> debug_pin_enable; endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup");
  a_halt: assert property (p_halt) else $error("peripheral clock in stop");
  a_osc: assert property (p_osc) else $error("oscillator outside standby");
  a_off: assert property (p_off) else $error("clock generator not fully off");
  a_kbi: assert property (p_kbi) else $error("keypad wake in deep stop");
  a_vec: assert property (p_vec) else $error("two resume vectors");
  a_lost: assert property (p_lost) else $error("ram lost without reset");
  a_rst: assert property (p_rst) else $error("register reset mismatch");
  a_ill: assert property (p_ill) else $error("illegal reset without stop");
  a_dbg: assert property (p_dbg) else $error("debug pin not default");
  c_ill: cover property (illegal_stop_reset);
  c_lost: cover property (wake.ram_lost);
  c_osc: cover property (power.cgen_osc_run);
  c_irq: cover property (low_volt_irq);
endmodule

bind smpc_top smpc_top_sva i_smpc_top_sva (.clk, .sys_rst, .psel, .penable, .pready, .stop_exec, .power,
  .wake, .regs_reset, .illegal_stop_reset, .low_volt_irq, .debug_pin_enable);
`default_nettype wire

// >>> verif/smpc_top_tb.sv
// Self-checking bench for the stop mode power control block.
`include "smpc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module smpc_top_tb;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, ill;
  logic        stop_exec, wake_irq_event, wake_reset_event, wdog_service;
  logic        debug_entry_enable, low_volt_raw, regs_reset, low_volt_irq;
  logic        illegal_stop_reset, watchdog_reset, low_volt_reset, debug_pin_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  opt;
  logic [3:0]  seen;
  integer      seed, errors, comparisons, n;
  smpc_pkg::smpc_power_t power;
  smpc_pkg::smpc_wake_t  wake;

  smpc_top i_smpc_top (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .stop_exec, .wake_irq_event, .wake_reset_event, .wdog_service, .debug_entry_enable, .low_volt_raw,
    .power, .wake, .regs_reset, .low_volt_irq, .illegal_stop_reset, .watchdog_reset, .low_volt_reset,
    .debug_pin_enable);

  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // Wake pulses last one cycle, so they are gathered here for later comparison.
  always @(posedge clk) seen <= seen | {wake.cpu_take_irq, wake.cpu_take_reset, wake.ram_lost, wake.periph_reset};

  function automatic logic [31:0] opt_read(input logic [7:0] v);
    return {24'h0, v & 8'hF3};
  endfunction

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // The answer is taken at the rising edge where pready is seen high, before the design updates.
    n = 0;
    @(posedge clk);
    while (pready !== 1'h1 && n < 40)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 40) errors++;
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string name);
    apb(1'h0, a, 32'h0);
    chk(name, rd, exp);
    chk("pslverr", pslverr, 1'h0);
  endtask

  task automatic stop_pulse();
    @(posedge clk);
    stop_exec <= 1'h1;
    @(negedge clk);
    ill = illegal_stop_reset;
    @(posedge clk);
    stop_exec <= 1'h0;
    @(negedge clk);
  endtask

  task automatic wake_pulse(input logic by_reset);
    seen = 4'h0;
    @(posedge clk);
    wake_irq_event <= !by_reset;
    wake_reset_event <= by_reset;
    @(posedge clk);
    wake_irq_event <= 1'h0;
    wake_reset_event <= 1'h0;
    for (n = 0; n < 20 && power.run_clk_en !== 1'h1; n++) @(negedge clk);
    repeat (3) @(negedge clk);
  endtask

  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #40000;
    errors++;
    conclude();
  end

  initial
  begin
    {sys_rst, seed, errors, comparisons, seen} = {1'h1, 32'd69, 64'd0, 4'h0};
    {psel, penable, pwrite, paddr, pwdata, stop_exec, wake_irq_event, wake_reset_event} = '0;
    {wdog_service, debug_entry_enable, low_volt_raw} = '0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'h0;
    rdchk(`SMPC_OFS_OPTIONS, 32'hC2, "options_reset");
    rdchk(`SMPC_OFS_PMC1, 32'h0, "pmc1_reset");
    rdchk(12'h020, 32'h0, "unmapped");
    stop_pulse();
    chk("illegal_stop", ill, 1'h1);
    $display("test reset_values done");
    opt = $random(seed);
    opt = (opt & 8'h5F) | 8'h21;
    apb(1'h1, `SMPC_OFS_OPTIONS, {24'h0, opt});
    apb(1'h1, `SMPC_OFS_OPTIONS, {24'h0, ~opt});
    rdchk(`SMPC_OFS_OPTIONS, opt_read(opt), "options_once");
    chk("debug_pin", debug_pin_enable, opt[1]);
    chk("no_watchdog", watchdog_reset, 1'h0);
    apb(1'h1, `SMPC_OFS_PMC1, 32'h20);
    low_volt_raw <= 1'h1;
    repeat (4) @(posedge clk);
    rdchk(`SMPC_OFS_PMC1, 32'h20, "lv_gated");
    apb(1'h1, `SMPC_OFS_PMC1, 32'h34);
    repeat (4) @(posedge clk);
    rdchk(`SMPC_OFS_PMC1, 32'hB4, "lv_flag");
    chk("lv_irq", {low_volt_irq, low_volt_reset}, 2'h3);
    low_volt_raw <= 1'h0;
    repeat (4) @(posedge clk);
    apb(1'h1, `SMPC_OFS_PMC1, 32'h74);
    rdchk(`SMPC_OFS_PMC1, 32'h34, "lv_ack");
    chk("lv_irq_off", low_volt_irq, 1'h0);
    apb(1'h1, `SMPC_OFS_PMC1, 32'h0);
    $display("test low_volt done");
    stop_pulse();
    chk("stop3", {ill, power.cgen_standby, power.cgen_off, power.cgen_osc_run, power.periph_clk_en,
      power.conv_enable, power.reg_standby, power.keypad_wake_en}, 8'h53);
    wake_pulse(1'h0);
    chk("stop3_wake", seen, 4'h8);
    rdchk(`SMPC_OFS_OPTIONS, opt_read(opt), "stop3_keep");
    apb(1'h1, `SMPC_OFS_PMC2, 32'h3);
    stop_pulse();
    chk("stop2", {power.cgen_off, power.cgen_osc_run, power.keypad_wake_en, power.pins_latched}, 4'h9);
    wake_pulse(1'h0);
    chk("stop2_wake", seen, 4'h5);
    rdchk(`SMPC_OFS_OPTIONS, 32'hC2, "stop2_regs");
    rdchk(`SMPC_OFS_PMC2, 32'h8, "ppd_flag");
    chk("pins_held", power.pins_latched, 1'h1);
    apb(1'h1, `SMPC_OFS_PMC2, 32'h6);
    rdchk(`SMPC_OFS_PMC2, 32'h2, "ppd_ack");
    chk("pins_free", power.pins_latched, 1'h0);
    apb(1'h1, `SMPC_OFS_PMC2, 32'h3);
    rdchk(`SMPC_OFS_PMC2, 32'h2, "pd_once");
    apb(1'h1, `SMPC_OFS_OPTIONS, 32'h21);
    stop_pulse();
    chk("stop1", power.cgen_off, 1'h1);
    wake_pulse(1'h1);
    chk("stop1_wake", seen, 4'h7);
    rdchk(`SMPC_OFS_PMC2, 32'h0, "stop1_regs");
    $display("test stop_modes done");
    apb(1'h1, `SMPC_OFS_OPTIONS, 32'h20);
    apb(1'h1, `SMPC_OFS_PMC2, 32'h3);
    for (int i = 0; i < 2; i++)
    begin
      debug_entry_enable <= (i == 0);
      if (i == 1) apb(1'h1, `SMPC_OFS_PMC1, 32'h0C);
      stop_pulse();
      chk("forced_stop3", {power.run_clk_en, power.cgen_off, power.reg_standby}, 3'h0);
      wake_pulse(1'h0);
      chk("forced_wake", seen, 4'h8);
    end
    $display("test forced_stop3 done");
    conclude();
  end
endmodule
`default_nettype wire
